// ===== rtl/pbw_regs.vh
// constants of the bridge write-forwarding block
//
// Summary of operation
// - mwi control field 00: memory write and invalidate goes out as plain memory write
// - mwi control field 11: mwi disconnects at aligned cache line boundaries, at 4KB when the cache line size is invalid
// - with a valid cache line size and field 11, mwi disconnects the initiator on a line boundary
// - i/o and type 1 config writes are forwarded as delayed transactions
// - a delayed write carries one dword; disconnect after one data transfer
// - a first-seen delayed write is claimed with devsel and ended with retry
// - latch command, address, parity in the same cycle; data, byte enables at irdy
// - queue a delayed write only if not full and no same address/command entry
// - start delivery only at queue head with posted data drained
// - on target retry keep reissuing until transferred or error
// - after the attempt limit report system error, gated by the error enable
// - matching repeat with completed head entry gets devsel and trdy
// - a multi-dword repeat also gets stop with trdy
// - compare only bytes whose byte enables are low
// - repeats before delivery get retry and make no new entry
// - discard timer starts when a completion reaches the head, loaded from 78h
// - on discard timer expiry drop the completion and flag system error
// - posted write disconnects at 4KB when control bit 1 is 0, else line
// - posted mwi: invalid line size 4KB; valid size line boundary if room short
// - accept posted data while a dword of room remains; disconnect when full
// - keep taking delayed writes while a free queue entry exists
// - accept fast back-to-back writes; retry the second when no room
// - fast back-to-back enabled by command bit upstream, bridge control downstream
`ifndef PBW_REGS_VH
`define PBW_REGS_VH

// ==========================================
// register offsets
`define PBW_OFS_CHIP_CTRL 8'h40
`define PBW_OFS_MWI_CTRL 8'h74
`define PBW_OFS_RETRY_LIM 8'h78

// ==========================================
// fields and reset values
`define PBW_CC_WDISC_BIT 1
`define PBW_MWI_LO 7
`define PBW_MWI_HI 8
`define PBW_MWI_CONVERT 2'h0
`define PBW_MWI_LINE 2'h3
`define PBW_CHIP_CTRL_RST 32'h0000_0000
`define PBW_MWI_CTRL_RST 32'h0000_0000
`define PBW_RETRY_LIM_RST 32'h0100_0000

// ==========================================
// bus commands
`define PBW_CMD_IOW 4'h3
`define PBW_CMD_MW 4'h7
`define PBW_CMD_CFGW 4'hb
`define PBW_CMD_MWI 4'hf

// ==========================================
// queue
`define PBW_DQ_DEPTH 2

`endif

// ===== rtl/pbw_write_fwd.v
// write-forwarding target logic of a two-port pci bridge
`timescale 1ns/1ps
`include "pbw_regs.vh"

module pbw_write_fwd #(
	parameter [31:0] RETRY_LIM_RESET = `PBW_RETRY_LIM_RST
) (
	// clock and reset
	input wire CLOCK,
	input wire RST,
	// initiator bus, asynchronous to CLOCK
	input wire PCI_CLK,
	input wire FRAME_L,
	input wire IRDY_L,
	input wire [31:0] AD,
	input wire [3:0] CBE_L,
	input wire PAR,
	// target response pins
	output reg DEVSEL_L,
	output reg TRDY_L,
	output reg STOP_L,
	output reg TGT_OE,
	// configuration access
	input wire CFG_WR,
	input wire [7:0] CFG_ADDR,
	input wire [31:0] CFG_WDATA,
	output reg [31:0] CFG_RDATA,
	// loose control bits
	input wire [7:0] CLS,
	input wire SERR_EN,
	input wire FBB_EN_CMD,
	input wire FBB_EN_BRIDGE,
	input wire UPSTREAM,
	// posted write buffer
	input wire [7:0] POST_ROOM,
	input wire POSTED_EMPTY,
	output reg POST_WR,
	output reg [31:0] POST_ADDR,
	output reg [3:0] POST_CMD,
	output reg [31:0] POST_DATA,
	output reg [3:0] POST_BE_L,
	// delayed write delivery on the target bus
	output reg DLV_REQ,
	output reg [31:0] DLV_ADDR,
	output reg [3:0] DLV_CMD,
	output reg [31:0] DLV_DATA,
	output reg [3:0] DLV_BE_L,
	input wire DLV_DONE,
	input wire DLV_RETRY,
	input wire DLV_ERR,
	// error reporting
	output reg PRIMARY_SYSTEM_ERROR_OUT_L
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_CLAIM = 5'h02;
	localparam [4:0] ST_DDATA = 5'h04;
	localparam [4:0] ST_PDATA = 5'h08;
	localparam [4:0] ST_END = 5'h10;

	// ==========================================
	// functions
	function is_delayed;
		input [3:0] cmd;
		begin
			is_delayed = (cmd == `PBW_CMD_IOW) || (cmd == `PBW_CMD_CFGW);
		end
	endfunction

	function is_posted;
		input [3:0] cmd;
		begin
			is_posted = (cmd == `PBW_CMD_MW) || (cmd == `PBW_CMD_MWI);
		end
	endfunction

	function cls_valid;
		input [7:0] c;
		begin
			cls_valid = (c == 8'h01) || (c == 8'h02) || (c == 8'h04) || (c == 8'h08) ||
				(c == 8'h10);
		end
	endfunction

	function bytes_eq;
		input [31:0] a;
		input [31:0] b;
		input [3:0] be_l;
		integer k;
		begin
			bytes_eq = 1'b1;
			for (k = 0; k < 4; k = k + 1) begin
				if (!be_l[k] && (a[8*k +: 8] != b[8*k +: 8])) begin
					bytes_eq = 1'b0;
				end
			end
		end
	endfunction

	// ==========================================
	// synchronisers
	reg [39:0] sync1_reg;
	reg [39:0] sync2_reg;
	reg pclk_prev_reg;
	wire pe;
	wire frame_s;
	wire irdy_s;
	wire [31:0] ad_s;
	wire [3:0] cbe_s;
	wire par_s;

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			// idle bus levels: clock low, frame, irdy and byte enables high
			sync1_reg <= 40'h60_0000_001e;
			sync2_reg <= 40'h60_0000_001e;
			pclk_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= {PCI_CLK, FRAME_L, IRDY_L, AD, CBE_L, PAR};
			sync2_reg <= sync1_reg;
			pclk_prev_reg <= sync2_reg[39];
		end
	end

	assign pe = sync2_reg[39] & ~pclk_prev_reg;
	assign frame_s = ~sync2_reg[38];
	assign irdy_s = ~sync2_reg[37];
	assign ad_s = sync2_reg[36:5];
	assign cbe_s = sync2_reg[4:1];
	assign par_s = sync2_reg[0];

	// ==========================================
	// configuration registers
	reg [31:0] chip_ctrl_reg;
	reg [31:0] mwi_ctrl_reg;
	reg [31:0] retry_lim_reg;

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			chip_ctrl_reg <= `PBW_CHIP_CTRL_RST;
			mwi_ctrl_reg <= `PBW_MWI_CTRL_RST;
			retry_lim_reg <= `PBW_RETRY_LIM_RST;
			CFG_RDATA <= 32'h0000_0000;
		end else begin
			if (CFG_WR && CFG_ADDR == `PBW_OFS_CHIP_CTRL) begin
				chip_ctrl_reg <= CFG_WDATA;
			end
			if (CFG_WR && CFG_ADDR == `PBW_OFS_MWI_CTRL) begin
				mwi_ctrl_reg <= CFG_WDATA;
			end
			if (CFG_WR && CFG_ADDR == `PBW_OFS_RETRY_LIM) begin
				retry_lim_reg <= CFG_WDATA;
			end
			case (CFG_ADDR)
				`PBW_OFS_CHIP_CTRL: CFG_RDATA <= chip_ctrl_reg;
				`PBW_OFS_MWI_CTRL: CFG_RDATA <= mwi_ctrl_reg;
				`PBW_OFS_RETRY_LIM: CFG_RDATA <= retry_lim_reg;
				default: CFG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

	wire [1:0] mwi_mode = mwi_ctrl_reg[`PBW_MWI_HI:`PBW_MWI_LO];
	wire fbb_en = UPSTREAM ? FBB_EN_CMD : FBB_EN_BRIDGE;

	// ==========================================
	// delayed queue and matching
	reg [`PBW_DQ_DEPTH-1:0] q_vld;
	reg [`PBW_DQ_DEPTH-1:0] q_done;
	reg [31:0] q_addr [0:`PBW_DQ_DEPTH-1];
	reg [3:0] q_cmd [0:`PBW_DQ_DEPTH-1];
	reg [31:0] q_data [0:`PBW_DQ_DEPTH-1];
	reg [3:0] q_be [0:`PBW_DQ_DEPTH-1];
	reg q_apar [0:`PBW_DQ_DEPTH-1];
	reg q_dpar [0:`PBW_DQ_DEPTH-1];
	reg hd_reg;
	reg tl_reg;
	reg [31:0] a_addr_reg;
	reg [3:0] a_cmd_reg;
	reg a_par_reg;
	wire [`PBW_DQ_DEPTH-1:0] hit;
	wire q_full = &q_vld;

	genvar gi;
	generate
		for (gi = 0; gi < `PBW_DQ_DEPTH; gi = gi + 1) begin : g_hit
			assign hit[gi] = q_vld[gi] && q_addr[gi] == a_addr_reg && q_cmd[gi] == a_cmd_reg;
		end
	endgenerate

	wire head_cpl = q_vld[hd_reg] && q_done[hd_reg] && hit[hd_reg] && q_be[hd_reg] == cbe_s &&
		bytes_eq(q_data[hd_reg], ad_s, q_be[hd_reg]);

	// ==========================================
	// posted disconnect boundary for the next dword
	reg [4:0] state_reg;
	wire [31:0] nxt_addr = POST_ADDR + 32'h0000_0004;
	wire [7:0] cls_m1 = CLS - 8'h01;
	// stop is driven one phase ahead, so look past the dword of the next phase
	wire [31:0] cur_addr = (state_reg == ST_CLAIM) ? a_addr_reg : nxt_addr;
	wire [31:0] bnd_addr = cur_addr + 32'h0000_0004;
	wire at_4k = (bnd_addr[11:2] == 10'h000);
	wire at_line = ((bnd_addr[9:2] & cls_m1) == 8'h00);
	reg use_line;

	always @* begin
		if (a_cmd_reg == `PBW_CMD_MWI && mwi_mode == `PBW_MWI_LINE) begin
			use_line = 1'b1;
		end else if (a_cmd_reg == `PBW_CMD_MWI && mwi_mode != `PBW_MWI_CONVERT) begin
			use_line = cls_valid(CLS) && (POST_ROOM < CLS);
		end else begin
			use_line = chip_ctrl_reg[`PBW_CC_WDISC_BIT];
		end
	end

	wire bound = (use_line && cls_valid(CLS)) ? at_line : at_4k;

	// ==========================================
	// target sequencer, queue, delivery, timers
	reg [31:0] attempts_reg;
	reg [31:0] discard_reg;
	reg disc_run_reg;
	// events of this cycle: failed delivery, discard expiry, completed repeat
	wire dlv_fail = DLV_REQ && !DLV_DONE && (DLV_ERR || (DLV_RETRY &&
		attempts_reg + 32'h0000_0001 >= retry_lim_reg));
	wire disc_exp = pe && disc_run_reg && discard_reg == 32'h0000_0000;
	wire err_ev = dlv_fail || disc_exp;
	wire cpl_ev = pe && state_reg == ST_DDATA && irdy_s && head_cpl && !err_ev;
	wire pop_ev = err_ev || cpl_ev;

	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			DEVSEL_L <= 1'b1;
			TRDY_L <= 1'b1;
			STOP_L <= 1'b1;
			TGT_OE <= 1'b0;
			POST_WR <= 1'b0;
			POST_ADDR <= 32'h0000_0000;
			POST_CMD <= 4'h0;
			POST_DATA <= 32'h0000_0000;
			POST_BE_L <= 4'hf;
			DLV_REQ <= 1'b0;
			DLV_ADDR <= 32'h0000_0000;
			DLV_CMD <= 4'h0;
			DLV_DATA <= 32'h0000_0000;
			DLV_BE_L <= 4'hf;
			PRIMARY_SYSTEM_ERROR_OUT_L <= 1'b1;
			q_vld <= {`PBW_DQ_DEPTH{1'b0}};
			q_done <= {`PBW_DQ_DEPTH{1'b0}};
			hd_reg <= 1'b0;
			tl_reg <= 1'b0;
			a_addr_reg <= 32'h0000_0000;
			a_cmd_reg <= 4'h0;
			a_par_reg <= 1'b0;
			attempts_reg <= 32'h0000_0000;
			discard_reg <= 32'h0000_0000;
			disc_run_reg <= 1'b0;
		end else begin
			POST_WR <= 1'b0;
			// delivery of the head entry
			DLV_ADDR <= q_addr[hd_reg];
			DLV_CMD <= q_cmd[hd_reg];
			DLV_DATA <= q_data[hd_reg];
			DLV_BE_L <= q_be[hd_reg];
			if (DLV_REQ && (DLV_DONE || DLV_RETRY || DLV_ERR)) begin
				DLV_REQ <= 1'b0;
				if (DLV_DONE) begin
					q_done[hd_reg] <= 1'b1;
					attempts_reg <= 32'h0000_0000;
					discard_reg <= retry_lim_reg;
					disc_run_reg <= 1'b1;
				end else if (!dlv_fail) begin
					attempts_reg <= attempts_reg + 32'h0000_0001;
				end
			end else begin
				DLV_REQ <= q_vld[hd_reg] && !q_done[hd_reg] && POSTED_EMPTY;
			end
			// discard timer on pci clock edges
			if (pe && disc_run_reg && !disc_exp) begin
				discard_reg <= discard_reg - 32'h0000_0001;
			end
			if (pe) begin
				PRIMARY_SYSTEM_ERROR_OUT_L <= 1'b1;
				case (state_reg)
					ST_IDLE: begin
						TGT_OE <= 1'b0;
						if (frame_s) begin
							a_addr_reg <= ad_s;
							a_cmd_reg <= cbe_s;
							a_par_reg <= par_s;
							state_reg <= ST_CLAIM;
						end
					end
					ST_CLAIM: begin
						if (is_delayed(a_cmd_reg)) begin
							TGT_OE <= 1'b1;
							DEVSEL_L <= 1'b0;
							state_reg <= ST_DDATA;
						end else if (is_posted(a_cmd_reg)) begin
							TGT_OE <= 1'b1;
							DEVSEL_L <= 1'b0;
							POST_ADDR <= a_addr_reg;
							POST_CMD <= (a_cmd_reg == `PBW_CMD_MWI && mwi_mode == `PBW_MWI_CONVERT) ?
								`PBW_CMD_MW : a_cmd_reg;
							if (POST_ROOM == 8'h00) begin
								STOP_L <= 1'b0;
								state_reg <= ST_END;
							end else begin
								TRDY_L <= 1'b0;
								STOP_L <= !(POST_ROOM == 8'h01 || a_addr_reg[1:0] != 2'b00 || bound);
								state_reg <= ST_PDATA;
							end
						end else begin
							state_reg <= ST_IDLE;
						end
					end
					ST_DDATA: begin
						if (irdy_s) begin
							STOP_L <= 1'b0;
							state_reg <= ST_END;
							if (head_cpl && !err_ev) begin
								TRDY_L <= 1'b0;
								STOP_L <= !frame_s;
							end else if (!(|hit) && !q_full) begin
								q_vld[tl_reg] <= 1'b1;
								q_done[tl_reg] <= 1'b0;
								q_addr[tl_reg] <= a_addr_reg;
								q_cmd[tl_reg] <= a_cmd_reg;
								q_apar[tl_reg] <= a_par_reg;
								q_data[tl_reg] <= ad_s;
								q_be[tl_reg] <= cbe_s;
								q_dpar[tl_reg] <= par_s;
								tl_reg <= ~tl_reg;
							end
							// repeats that hit a pending entry only see retry
						end
					end
					ST_PDATA: begin
						if (irdy_s) begin
							POST_WR <= 1'b1;
							POST_DATA <= ad_s;
							POST_BE_L <= cbe_s;
							POST_ADDR <= nxt_addr;
							if (!STOP_L || !frame_s) begin
								TRDY_L <= 1'b1;
								STOP_L <= frame_s ? 1'b0 : 1'b1;
								state_reg <= ST_END;
							end else if (bound || POST_ROOM <= 8'h02) begin
								STOP_L <= 1'b0;
							end
						end
					end
					ST_END: begin
						DEVSEL_L <= 1'b1;
						TRDY_L <= 1'b1;
						STOP_L <= 1'b1;
						if (frame_s && fbb_en && DEVSEL_L == 1'b1) begin
							a_addr_reg <= ad_s;
							a_cmd_reg <= cbe_s;
							a_par_reg <= par_s;
							state_reg <= ST_CLAIM;
						end else if (!frame_s && !irdy_s) begin
							state_reg <= ST_IDLE;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
				if (err_ev && SERR_EN) begin
					PRIMARY_SYSTEM_ERROR_OUT_L <= 1'b0;
				end
			end else if (err_ev && SERR_EN) begin
				PRIMARY_SYSTEM_ERROR_OUT_L <= 1'b0;
			end
			if (pop_ev) begin
				q_vld[hd_reg] <= 1'b0;
				q_done[hd_reg] <= 1'b0;
				hd_reg <= ~hd_reg;
				attempts_reg <= 32'h0000_0000;
				disc_run_reg <= 1'b0;
			end
		end
	end

endmodule // pbw_write_fwd

// ===== dv/pbw_write_fwd_properties.sv
// concurrent checks on the write-forwarding block ports
`timescale 1ns/1ps
`include "pbw_regs.vh"
module pbw_write_fwd_properties (
	// clock and reset
	input wire CLOCK,
	input wire RST,
	// target response
	input wire DEVSEL_L,
	input wire TRDY_L,
	input wire STOP_L,
	input wire TGT_OE,
	// configuration and loose bits
	input wire CFG_WR,
	input wire [7:0] CFG_ADDR,
	input wire [31:0] CFG_WDATA,
	input wire SERR_EN,
	// posted buffer
	input wire [7:0] POST_ROOM,
	input wire POSTED_EMPTY,
	input wire POST_WR,
	input wire [3:0] POST_CMD,
	// delayed delivery
	input wire DLV_REQ,
	input wire [31:0] DLV_ADDR,
	input wire [3:0] DLV_CMD,
	input wire [31:0] DLV_DATA,
	input wire DLV_DONE,
	input wire DLV_RETRY,
	input wire DLV_ERR,
	// error reporting
	input wire PRIMARY_SYSTEM_ERROR_OUT_L
);
	logic [1:0] mwi_reg;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// shadow of the mwi control field
	always @(posedge CLOCK or posedge RST) begin
		if (RST)
			mwi_reg <= 2'h0;
		else if (CFG_WR && CFG_ADDR == `PBW_OFS_MWI_CTRL)
			mwi_reg <= CFG_WDATA[8:7];
	end
	sequence dlv_gap_s;
		!DLV_REQ ##1 DLV_REQ;
	endsequence
	sequence serr_low_s;
		##[0:2] !PRIMARY_SYSTEM_ERROR_OUT_L;
	endsequence
	property retry_reissue_p;
		DLV_RETRY && SERR_EN |=> dlv_gap_s or serr_low_s;
	endproperty
	// ==========================================
	// assertions
	tgt_drive_a: assert property (!DEVSEL_L |-> TGT_OE)
		else $error("response without output enable");
	claim_with_a: assert property (!TRDY_L || !STOP_L |-> !DEVSEL_L)
		else $error("trdy or stop without devsel");
	dlv_cmd_a: assert property ($rose(DLV_REQ) |->
		DLV_CMD == `PBW_CMD_IOW || DLV_CMD == `PBW_CMD_CFGW)
		else $error("delayed delivery of a wrong command");
	dlv_order_a: assert property ($rose(DLV_REQ) |-> $past(POSTED_EMPTY))
		else $error("delivery ahead of posted data");
	dlv_hold_a: assert property (DLV_REQ && !DLV_DONE && !DLV_RETRY && !DLV_ERR |=>
		DLV_REQ && $stable(DLV_ADDR) && $stable(DLV_DATA))
		else $error("delivery request not held");
	retry_reissue_a: assert property (retry_reissue_p)
		else $error("retried write not reissued");
	serr_gate_a: assert property ($fell(PRIMARY_SYSTEM_ERROR_OUT_L) |-> $past(SERR_EN))
		else $error("system error while disabled");
	post_room_a: assert property (POST_WR |-> POST_ROOM != 8'h00)
		else $error("posted data taken with no room");
	mwi_conv_a: assert property (POST_WR && mwi_reg == `PBW_MWI_CONVERT |->
		POST_CMD == `PBW_CMD_MW)
		else $error("mwi not converted");
endmodule // pbw_write_fwd_properties

bind pbw_write_fwd pbw_write_fwd_properties chk_i (.CLOCK, .RST, .DEVSEL_L, .TRDY_L, .STOP_L,
	.TGT_OE, .CFG_WR, .CFG_ADDR, .CFG_WDATA, .SERR_EN, .POST_ROOM, .POSTED_EMPTY, .POST_WR,
	.POST_CMD, .DLV_REQ, .DLV_ADDR, .DLV_CMD, .DLV_DATA, .DLV_DONE, .DLV_RETRY, .DLV_ERR,
	.PRIMARY_SYSTEM_ERROR_OUT_L);

// ===== dv/pbw_target_model.sv
// far-side target bus model answering delayed write deliveries
`timescale 1ns/1ps
module pbw_target_model (
	// clock and reset
	input wire clk,
	input wire rst,
	// delivery handshake
	input wire req,
	input wire [7:0] n_retry,
	input wire [7:0] lat,
	output logic done,
	output logic retry
);
	logic [7:0] wait_reg;
	logic [7:0] tries_reg;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 8'h00;
			tries_reg <= 8'h00;
			done <= 1'b0;
			retry <= 1'b0;
		end else begin
			done <= 1'b0;
			retry <= 1'b0;
			if (!req) begin
				wait_reg <= 8'h00;
			end else if (wait_reg == lat) begin
				wait_reg <= wait_reg + 8'h01;
				// one answer per attempt, retrying n_retry times first
				if (tries_reg < n_retry) begin
					retry <= 1'b1;
					tries_reg <= tries_reg + 8'h01;
				end else begin
					done <= 1'b1;
					tries_reg <= 8'h00;
				end
			end else if (wait_reg < lat) begin
				wait_reg <= wait_reg + 8'h01;
			end
		end
	end
endmodule // pbw_target_model

// ===== dv/pbw_write_fwd_bench.sv
// self-checking bench of the write-forwarding block
`timescale 1ns/1ps
`include "pbw_regs.vh"
module pbw_write_fwd_bench;
	logic CLOCK = 0, RST = 1, PCI_CLK = 0, FRAME_L = 1, IRDY_L = 1, PAR = 0, CFG_WR = 0;
	logic SERR_EN = 1, FBB_EN_CMD = 0, FBB_EN_BRIDGE = 0, UPSTREAM = 0, POSTED_EMPTY = 1;
	logic DLV_ERR = 0, DEVSEL_L, TRDY_L, STOP_L, TGT_OE, POST_WR, DLV_REQ, DLV_DONE, DLV_RETRY;
	logic PRIMARY_SYSTEM_ERROR_OUT_L;
	logic [31:0] AD = '0, CFG_WDATA = '0, CFG_RDATA, POST_ADDR, POST_DATA, DLV_ADDR, DLV_DATA;
	logic [3:0] CBE_L = 4'hf, POST_CMD, POST_BE_L, DLV_CMD, DLV_BE_L;
	logic [7:0] CFG_ADDR = '0, CLS = '0, POST_ROOM = 8'h10, n_retry = '0, lat = 8'h28;
	integer err_total = 0, compares = 0, n_post = 0, n_try = 0, n_serr = 0;
	pbw_write_fwd uut (.CLOCK, .RST, .PCI_CLK, .FRAME_L, .IRDY_L, .AD, .CBE_L, .PAR, .DEVSEL_L,
		.TRDY_L, .STOP_L, .TGT_OE, .CFG_WR, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .CLS, .SERR_EN,
		.FBB_EN_CMD, .FBB_EN_BRIDGE, .UPSTREAM, .POST_ROOM, .POSTED_EMPTY, .POST_WR, .POST_ADDR,
		.POST_CMD, .POST_DATA, .POST_BE_L, .DLV_REQ, .DLV_ADDR, .DLV_CMD, .DLV_DATA, .DLV_BE_L,
		.DLV_DONE, .DLV_RETRY, .DLV_ERR, .PRIMARY_SYSTEM_ERROR_OUT_L);
	pbw_target_model tm (.clk(CLOCK), .rst(RST), .req(DLV_REQ), .n_retry(n_retry), .lat(lat),
		.done(DLV_DONE), .retry(DLV_RETRY));
	always #50 CLOCK = ~CLOCK;
	initial #137 forever #400 PCI_CLK = ~PCI_CLK;
	always @(posedge CLOCK) begin
		if (POST_WR) n_post++;
		if (DLV_RETRY) n_try++;
		if (!PRIMARY_SYSTEM_ERROR_OUT_L) n_serr++;
	end
	// ==========================================
	// helpers
	task tick(input integer n); repeat (n) @(posedge CLOCK); #5; endtask
	task pclk; @(negedge PCI_CLK); tick(1); endtask
	task chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task cfg_wr(input [7:0] a, input [31:0] d);
		CFG_ADDR = a; CFG_WDATA = d; CFG_WR = 1; tick(1); CFG_WR = 0; tick(1);
	endtask
	task cfg_rd(input [7:0] a, output [31:0] d); CFG_ADDR = a; tick(2); d = CFG_RDATA; endtask
	// initiator write of n dwords; t and s report trdy and stop seen
	task bus_wr(input [3:0] cmd, input [31:0] a, d, input [3:0] be, input integer n,
		output logic t, s);
		integer i, k;
		logic last;
		begin
		i = 0; last = 0; t = 0; s = 0;
		pclk(); FRAME_L = 0; AD = a; CBE_L = cmd; PAR = ^{a, cmd};
		pclk(); IRDY_L = 0; AD = d; CBE_L = be; PAR = ^{d, be}; FRAME_L = (n == 1);
		for (k = 0; k < 12; k++) begin
			pclk();
			if (!TRDY_L || !STOP_L) begin
				t |= !TRDY_L; s |= !STOP_L; i++;
				if (!STOP_L || i == n) begin
					if (n > 1) FRAME_L = 1;
					last = 1;
					break;
				end
			end
		end
		pclk(); IRDY_L = 1; if (!last) FRAME_L = 1; pclk(); pclk();
		end
	endtask
	task wait_done(output integer w);
		w = 0;
		while (DLV_DONE !== 1'b1 && w < 400) begin
			tick(1);
			w++;
		end
	endtask
	// ==========================================
	// scenarios
	task t_regs;
		logic [31:0] v;
		begin
		cfg_rd(`PBW_OFS_RETRY_LIM, v); chk(v === `PBW_RETRY_LIM_RST, "limit reset");
		cfg_rd(`PBW_OFS_CHIP_CTRL, v); chk(v === 32'h0000_0000, "chip reset");
		cfg_rd(`PBW_OFS_MWI_CTRL, v); chk(v === 32'h0000_0000, "mwi reset");
		cfg_wr(8'h10, 32'hffff_ffff); cfg_rd(8'h10, v); chk(v === 32'h0000_0000, "unmapped read");
		cfg_wr(`PBW_OFS_RETRY_LIM, 32'h0000_0010); cfg_rd(`PBW_OFS_RETRY_LIM, v);
		chk(v === 32'h0000_0010, "limit write");
		end
	endtask
	task t_posted;
		logic t, s;
		integer c;
		begin
		// mw 4KB, mwi converted 4KB, mw line, mwi line mode
		for (c = 0; c < 4; c++) begin
			CLS = (c >= 2) ? 8'h04 : 8'h00; UPSTREAM = c[0];
			cfg_wr(`PBW_OFS_CHIP_CTRL, (c == 2) ? 32'h0000_0002 : 32'h0000_0000); n_post = 0;
			cfg_wr(`PBW_OFS_MWI_CTRL, (c == 3) ? 32'h0000_0180 : 32'h0000_0000);
			bus_wr(c[0] ? `PBW_CMD_MWI : `PBW_CMD_MW, c >= 2 ? 32'h0000_0108 : 32'h0000_0ff8,
				32'h5a5a_0001, 4'h0, 4, t, s);
			tick(4);
			chk(n_post == 2 && t && s, "posted boundary");
		end
		POST_ROOM = 8'h00; n_post = 0; bus_wr(`PBW_CMD_MW, 32'h0000_0200, '0, 4'h0, 2, t, s);
		chk(!t && s && n_post == 0, "full buffer retry");
		POST_ROOM = 8'h10;
		end
	endtask
	task t_delayed;
		logic t, s;
		logic [3:0] cmd;
		integer c, w;
		begin
		n_retry = 8'h01;
		for (c = 0; c < 2; c++) begin
			cmd = c ? `PBW_CMD_CFGW : `PBW_CMD_IOW; POSTED_EMPTY = 0; n_try = 0;
			bus_wr(cmd, 32'h0000_1230, 32'h1234_5678, 4'h1, 1, t, s);
			chk(!t && s, "first write retried");
			tick(20); chk(DLV_REQ === 1'b0, "waits on posted data");
			POSTED_EMPTY = 1;
			bus_wr(cmd, 32'h0000_1230, 32'h1234_5678, 4'h1, 1, t, s);
			chk(!t && s, "early repeat retried");
			chk(DLV_ADDR === 32'h0000_1230 && DLV_DATA === 32'h1234_5678 && DLV_BE_L === 4'h1
				&& DLV_CMD === cmd, "queued fields");
			wait_done(w); chk(w < 400 && n_try == 1, "reissued after retry");
			bus_wr(cmd, 32'h0000_1230, 32'h1234_56aa, 4'h1, 2, t, s);
			chk(t && s, "repeat completes");
			tick(20); chk(DLV_REQ === 1'b0, "no duplicate entry");
		end
		end
	endtask
	task t_discard;
		logic t, s;
		integer w;
		begin
		bus_wr(`PBW_CMD_IOW, 32'h0000_2000, 32'hcafe_0001, 4'h0, 1, t, s); wait_done(w);
		w = 0;
		while (PRIMARY_SYSTEM_ERROR_OUT_L !== 1'b0 && w < 400) begin tick(1); w++; end
		chk(w > 100 && w < 250, "completion discarded");
		end
	endtask
	task t_limit;
		logic t, s;
		integer w;
		begin
		cfg_wr(`PBW_OFS_RETRY_LIM, 32'h0000_0004); n_retry = 8'hff; lat = 8'h01; n_try = 0;
		n_serr = 0;
		// the error pulse may come and go while the initiator is still on the bus
		bus_wr(`PBW_CMD_IOW, 32'h0000_3000, 32'h0000_0bad, 4'h0, 1, t, s); w = 0;
		while (n_serr == 0 && w < 400) begin tick(1); w++; end
		tick(20);
		chk(w < 400 && n_try == 4 && DLV_REQ === 1'b0, "attempt limit error");
		end
	endtask
	// ==========================================
	// run control
	task finish_test;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		tick(5); RST = 0; tick(3);
		t_regs; t_posted; t_delayed; t_discard; t_limit;
		finish_test();
	end
	initial begin
		#2_000_000;
		err_total++;
		finish_test();
	end
endmodule // pbw_write_fwd_bench
